// ==== include/tower_alarm_status_regs_defines.vh ====
`ifndef TOWER_ALARM_STATUS_REGS_DEFINES_VH
`define TOWER_ALARM_STATUS_REGS_DEFINES_VH

// Register numbers
`define REG_STATUS_EVENT_COUNTER 16'h0046
`define REG_CONFIG_CHANGE_COUNTER 16'h0047
`define REG_ALARM_INDICATION_WORD 16'h0048
`define REG_ALARM_INDICATION_CHANGED 16'h0049
`define REG_BEACON_ALARM_FLAG 16'h004E
`define REG_BEACON_ALARM_CHANGED 16'h004F
`define REG_MARKER_ALARM_FLAG 16'h0052
`define REG_MARKER_ALARM_CHANGED 16'h0053
`define REG_CURRENT_OPERATING_MODE 16'h0056
`define REG_SENSOR_DETECTED_MODE 16'h0057
`define REG_LEADER_COMMANDED_MODE 16'h0058

// Alarm word bit positions
`define BIT_POWERED_UP 0
`define BIT_SITE_VOLTAGE 3
`define BIT_LIGHT_SENSOR 4
`define BIT_TIMING_SYNC 6
`define BIT_CONFIG_CONFLICT 7
`define BIT_OVERRIDE 8
`define BIT_INSPECTION 9
`define BIT_FLASH_DRIVE 10
`define BIT_PRIMARY_FW 11
`define BIT_LEADER_LOST 12
`define ALARM_USED_MASK 16'h1FD9

// Values
`define UNUSED_READ_VALUE 16'hFFFF
`define COUNTER_RESET 16'h0000
`define MODE_DAY 16'h0001
`define MODE_RED_NIGHT 16'h0003
`define ALARM_MISS_LIMIT 3'h4

// Timing
`define CLOCK_HZ 40000000
`define SENSOR_WINDOW_HOURS 19
`define SYNC_WINDOW_HOURS 1
`define LEADER_WINDOW_MINUTES 10
`define SENSOR_WINDOW_SECONDS (`SENSOR_WINDOW_HOURS * 3600)
`define SYNC_WINDOW_SECONDS (`SYNC_WINDOW_HOURS * 3600)
`define LEADER_WINDOW_SECONDS (`LEADER_WINDOW_MINUTES * 60)

`endif

// ==== verilog/tower_alarm_status_regs.v ====
// Behaviour
// R1 - Status event counter counts reportable events
// R2 - Configuration counter counts configuration changes
// R3 - Bit 0 set at power-up, cleared first read
// R4 - Bit 3 flags site voltage fault
// R5 - Bit 4 flags no mode change 19 hours
// R6 - Bit 6 flags timing loss or antenna fault
// R7 - Bit 7 flags contradictory switch settings
// R8 - Bits 8-10 show override, inspection, drive
// R9 - Bit 11 flags failsafe firmware running
// R10 - Bit 12 flags follower lost leader 10 minutes
// R11 - Changed word records changes since last poll
// R12 - Beacon alarm on four missed flashes
// R13 - Beacon changed bit since last poll
// R14 - Marker alarm on four bad periods
// R15 - Marker changed bit since last poll
// R16 - Unused addresses read all ones
// R17 - Mode registers read 1 day, 3 night
// R18 - Leader commanded mode register on followers
// R19 - All registers read-only, writes ignored
// R20 - Counters wrap from maximum to zero
// R21 - Reserved bits zero, changed words clear on read
`include "tower_alarm_status_regs_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module tower_alarm_status_regs #(
    parameter TICK_CYCLES = `CLOCK_HZ,
    parameter SENSOR_WINDOW = `SENSOR_WINDOW_SECONDS,
    parameter SYNC_WINDOW = `SYNC_WINDOW_SECONDS,
    parameter LEADER_WINDOW = `LEADER_WINDOW_SECONDS,
    parameter NUM_BEACONS = 2,
    parameter NUM_MARKERS = 4,
    parameter NUM_RATE_SWITCHES = 4
) (
    input wire sys_clk,
    input wire rst,
    input wire [15:0] regAddr,
    input wire rdStrobe,
    input wire wrStrobe,
    input wire [15:0] wrData,
    output reg [15:0] rdData,
    output reg rdValid,
    input wire statusEvent,
    input wire configChange,
    input wire voltageFault,
    input wire sensorNight,
    input wire timingPulse,
    input wire antennaFault,
    input wire [NUM_RATE_SWITCHES-1:0] flashRateSelect,
    input wire overrideActive,
    input wire inspectionActive,
    input wire flashDriveInserted,
    input wire failsafeRunning,
    input wire isFollower,
    input wire leaderSync,
    input wire leaderModeNight,
    input wire currentNight,
    input wire [NUM_BEACONS-1:0] beaconMissed,
    input wire [NUM_BEACONS-1:0] beaconFlashed,
    input wire [NUM_MARKERS-1:0] markerBad,
    input wire [NUM_MARKERS-1:0] markerGood
);

    function [15:0] modeCode;
        input night;
        begin
            modeCode = night ? `MODE_RED_NIGHT : `MODE_DAY;
        end
    endfunction

    function [31:0] nextTimer;
        input [31:0] count;
        input restart;
        input tick;
        input [31:0] limit;
        begin
            if (restart)
                nextTimer = 32'h00000000;
            else if (tick && count < limit)
                nextTimer = count + 32'h00000001;
            else
                nextTimer = count;
        end
    endfunction

    function [2:0] nextMiss;
        input [2:0] count;
        input bad;
        input good;
        begin
            if (good)
                nextMiss = 3'h0;
            else if (bad && count < `ALARM_MISS_LIMIT)
                nextMiss = count + 3'h1;
            else
                nextMiss = count;
        end
    endfunction

    reg [31:0] tickCount;
    reg secondTick;
    reg [31:0] sensorTimer;
    reg [31:0] syncTimer;
    reg [31:0] leaderTimer;
    reg lastSensorNight;
    reg [NUM_RATE_SWITCHES-1:0] lastRateSelect;
    reg poweredUp;
    reg [15:0] statusCount;
    reg [15:0] configCount;
    reg [15:0] alarmWord;
    reg [15:0] alarmChanged;
    reg beaconAlarm;
    reg beaconChanged;
    reg markerAlarm;
    reg markerChanged;
    reg leaderNight;
    reg [2:0] beaconMiss [0:NUM_BEACONS-1];
    reg [2:0] markerMiss [0:NUM_MARKERS-1];
    reg [15:0] next_alarmWord;
    reg next_beaconAlarm;
    reg next_markerAlarm;
    reg [15:0] readValue;
    integer i;
    integer j;
    integer sw;
    integer bk;
    integer mk;
    integer ones;

    wire readAlarm = rdStrobe && regAddr == `REG_ALARM_INDICATION_WORD;
    wire readChanged = rdStrobe && regAddr == `REG_ALARM_INDICATION_CHANGED;
    wire readBeaconChanged = rdStrobe && regAddr == `REG_BEACON_ALARM_CHANGED;
    wire readMarkerChanged = rdStrobe && regAddr == `REG_MARKER_ALARM_CHANGED;
    wire alarmDiff = |(next_alarmWord ^ alarmWord);
    wire beaconDiff = next_beaconAlarm != beaconAlarm;
    wire markerDiff = next_markerAlarm != markerAlarm;

    // One-second enable
    always @(posedge sys_clk) begin
        if (rst) begin
            tickCount <= 32'h00000000;
            secondTick <= 1'b0;
        end else if (tickCount >= TICK_CYCLES - 1) begin
            tickCount <= 32'h00000000;
            secondTick <= 1'b1;
        end else begin
            tickCount <= tickCount + 32'h00000001;
            secondTick <= 1'b0;
        end
    end

    // Light sensor mode change watchdog
    always @(posedge sys_clk) begin
        if (rst) begin
            lastSensorNight <= 1'b0;
            sensorTimer <= 32'h00000000;
        end else begin
            lastSensorNight <= sensorNight;
            sensorTimer <= nextTimer(sensorTimer, sensorNight != lastSensorNight,
                secondTick, SENSOR_WINDOW); // R5
        end
    end

    // Timing signal watchdog
    always @(posedge sys_clk) begin
        if (rst) begin
            syncTimer <= 32'h00000000;
        end else begin
            syncTimer <= nextTimer(syncTimer, timingPulse, secondTick, SYNC_WINDOW); // R6
        end
    end

    // Leader signal watchdog, held at zero when not a follower
    always @(posedge sys_clk) begin
        if (rst) begin
            leaderTimer <= 32'h00000000;
        end else begin
            leaderTimer <= nextTimer(leaderTimer, leaderSync || !isFollower,
                secondTick, LEADER_WINDOW); // R10
        end
    end

    // Switch bank history for change detection
    always @(posedge sys_clk) begin
        if (rst) begin
            lastRateSelect <= {NUM_RATE_SWITCHES{1'b0}};
        end else begin
            lastRateSelect <= flashRateSelect;
        end
    end

    // Missed flash counters per beacon
    always @(posedge sys_clk) begin
        if (rst) begin
            for (i = 0; i < NUM_BEACONS; i = i + 1) begin
                beaconMiss[i] <= 3'h0;
            end
        end else begin
            for (i = 0; i < NUM_BEACONS; i = i + 1) begin
                beaconMiss[i] <= nextMiss(beaconMiss[i], beaconMissed[i], beaconFlashed[i]);
            end
        end
    end

    // Bad period counters per marker light
    always @(posedge sys_clk) begin
        if (rst) begin
            for (j = 0; j < NUM_MARKERS; j = j + 1) begin
                markerMiss[j] <= 3'h0;
            end
        end else begin
            for (j = 0; j < NUM_MARKERS; j = j + 1) begin
                markerMiss[j] <= nextMiss(markerMiss[j], markerBad[j], markerGood[j]);
            end
        end
    end

    // Next alarm word
    always @* begin
        next_alarmWord = 16'h0000; // R21
        next_alarmWord[`BIT_POWERED_UP] = poweredUp && !readAlarm; // R3
        next_alarmWord[`BIT_SITE_VOLTAGE] = voltageFault; // R4
        next_alarmWord[`BIT_LIGHT_SENSOR] = sensorTimer >= SENSOR_WINDOW; // R5
        next_alarmWord[`BIT_TIMING_SYNC] = syncTimer >= SYNC_WINDOW || antennaFault; // R6
        ones = 0;
        for (sw = 0; sw < NUM_RATE_SWITCHES; sw = sw + 1) begin
            ones = ones + flashRateSelect[sw];
        end
        next_alarmWord[`BIT_CONFIG_CONFLICT] = ones > 1; // R7
        next_alarmWord[`BIT_OVERRIDE] = overrideActive; // R8
        next_alarmWord[`BIT_INSPECTION] = inspectionActive; // R8
        next_alarmWord[`BIT_FLASH_DRIVE] = flashDriveInserted; // R8
        next_alarmWord[`BIT_PRIMARY_FW] = failsafeRunning; // R9
        next_alarmWord[`BIT_LEADER_LOST] = isFollower && leaderTimer >= LEADER_WINDOW; // R10
    end

    // Any beacon in alarm
    always @* begin
        next_beaconAlarm = 1'b0;
        for (bk = 0; bk < NUM_BEACONS; bk = bk + 1) begin
            if (beaconMiss[bk] >= `ALARM_MISS_LIMIT) begin
                next_beaconAlarm = 1'b1; // R12
            end
        end
    end

    // Any marker light in alarm
    always @* begin
        next_markerAlarm = 1'b0;
        for (mk = 0; mk < NUM_MARKERS; mk = mk + 1) begin
            if (markerMiss[mk] >= `ALARM_MISS_LIMIT) begin
                next_markerAlarm = 1'b1; // R14
            end
        end
    end

    // Power-up indication, dropped by the first alarm word read
    always @(posedge sys_clk) begin
        if (rst) begin
            poweredUp <= 1'b1;
        end else if (readAlarm) begin
            poweredUp <= 1'b0; // R3
        end
    end

    // Alarm word and changed word; set wins over the clear of a read
    always @(posedge sys_clk) begin
        if (rst) begin
            alarmWord <= 16'h0001;
            alarmChanged <= 16'h0000;
        end else begin
            alarmWord <= next_alarmWord & `ALARM_USED_MASK; // R21
            alarmChanged <= ((readChanged ? 16'h0000 : alarmChanged)
                | (next_alarmWord ^ alarmWord)) & `ALARM_USED_MASK; // R11 R21
        end
    end

    // Beacon alarm and its changed flag
    always @(posedge sys_clk) begin
        if (rst) begin
            beaconAlarm <= 1'b0;
            beaconChanged <= 1'b0;
        end else begin
            beaconAlarm <= next_beaconAlarm; // R12
            beaconChanged <= (beaconChanged && !readBeaconChanged) || beaconDiff; // R13
        end
    end

    // Marker alarm and its changed flag
    always @(posedge sys_clk) begin
        if (rst) begin
            markerAlarm <= 1'b0;
            markerChanged <= 1'b0;
        end else begin
            markerAlarm <= next_markerAlarm; // R14
            markerChanged <= (markerChanged && !readMarkerChanged) || markerDiff; // R15
        end
    end

    // Status event counter, wraps at its maximum
    always @(posedge sys_clk) begin
        if (rst) begin
            statusCount <= `COUNTER_RESET;
        end else if (statusEvent || alarmDiff || beaconDiff || markerDiff) begin
            statusCount <= statusCount + 16'h0001; // R1 R20
        end
    end

    // Configuration change counter, wraps at its maximum
    always @(posedge sys_clk) begin
        if (rst) begin
            configCount <= `COUNTER_RESET;
        end else if (configChange || flashRateSelect != lastRateSelect) begin
            configCount <= configCount + 16'h0001; // R2 R20
        end
    end

    // Mode last received from the leader
    always @(posedge sys_clk) begin
        if (rst) begin
            leaderNight <= 1'b0;
        end else if (isFollower && leaderSync) begin
            leaderNight <= leaderModeNight; // R18
        end
    end

    // Read decode
    always @* begin
        case (regAddr)
            `REG_STATUS_EVENT_COUNTER: readValue = statusCount; // R1
            `REG_CONFIG_CHANGE_COUNTER: readValue = configCount; // R2
            `REG_ALARM_INDICATION_WORD: readValue = alarmWord;
            `REG_ALARM_INDICATION_CHANGED: readValue = alarmChanged; // R11
            `REG_BEACON_ALARM_FLAG: readValue = {15'h0000, beaconAlarm}; // R12
            `REG_BEACON_ALARM_CHANGED: readValue = {15'h0000, beaconChanged}; // R13
            `REG_MARKER_ALARM_FLAG: readValue = {15'h0000, markerAlarm}; // R14
            `REG_MARKER_ALARM_CHANGED: readValue = {15'h0000, markerChanged}; // R15
            `REG_CURRENT_OPERATING_MODE: readValue = modeCode(currentNight); // R17
            `REG_SENSOR_DETECTED_MODE: readValue = modeCode(sensorNight); // R17
            `REG_LEADER_COMMANDED_MODE: readValue = modeCode(leaderNight); // R18
            default: readValue = `UNUSED_READ_VALUE; // R16
        endcase
    end

    // Read answer strobe; writes are ignored
    always @(posedge sys_clk) begin
        if (rst) begin
            rdValid <= 1'b0;
        end else begin
            rdValid <= rdStrobe; // R19
        end
    end

    // Read data, held until the next read
    always @(posedge sys_clk) begin
        if (rst) begin
            rdData <= 16'h0000;
        end else if (rdStrobe) begin
            rdData <= readValue;
        end
    end

endmodule // tower_alarm_status_regs

`default_nettype wire

// ==== verif/tower_alarm_status_regs_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module tower_alarm_status_props (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [15:0] regAddr,
    input wire logic rdStrobe,
    input wire logic [15:0] rdData,
    input wire logic rdValid,
    input wire logic voltageFault,
    input wire logic antennaFault,
    input wire logic overrideActive,
    input wire logic inspectionActive,
    input wire logic flashDriveInserted,
    input wire logic failsafeRunning,
    input wire logic currentNight
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    logic settled;
    logic rdA;
    logic [3:0] lv;
    always_ff @(posedge sys_clk) settled <= !rst;
    assign rdA = rdStrobe && settled && regAddr == 16'h0048;
    assign lv = {failsafeRunning, flashDriveInserted, inspectionActive, overrideActive};
    read_answer_a:
        assert property (rdStrobe |=> rdValid) else $error("read not answered");
    idle_hold_a:
        assert property (!rdStrobe |=> !rdValid && $stable(rdData)) else $error("stray answer");
    unused_ones_a:
        assert property (rdStrobe && regAddr inside {[16'h004A:16'h004D], 16'h0050, 16'h0051,
            16'h0054, 16'h0055} |=> rdData == 16'hFFFF) else $error("unused not ones");
    reserved_zero_a:
        assert property (rdStrobe && regAddr[15:1] == 15'h0024
            |=> (rdData & 16'hE026) == 16'h0000) else $error("reserved bit set");
    volt_bit_a:
        assert property (rdA && $stable(voltageFault) |=> rdData[3] == $past(voltageFault))
            else $error("voltage bit wrong");
    level_bits_a:
        assert property (rdA && $stable(lv) |=> rdData[11:8] == $past(lv))
            else $error("indication bits wrong");
    antenna_bit_a:
        assert property (rdA && antennaFault && $past(antennaFault) |=> rdData[6])
            else $error("antenna fault not shown");
    day_night_a:
        assert property (rdStrobe && settled && regAddr == 16'h0056 && $stable(currentNight)
            |=> rdData == ($past(currentNight) ? 16'h0003 : 16'h0001)) else $error("bad mode");
endmodule // tower_alarm_status_props
bind tower_alarm_status_regs tower_alarm_status_props props_i (.sys_clk, .rst, .regAddr,
    .rdStrobe, .rdData, .rdValid, .voltageFault, .antennaFault, .overrideActive,
    .inspectionActive, .flashDriveInserted, .failsafeRunning, .currentNight);
`default_nettype wire

// ==== verif/poll_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module poll_master (
    input wire logic sys_clk,
    input wire logic [15:0] rdData,
    input wire logic rdValid,
    output var logic [15:0] regAddr,
    output var logic rdStrobe,
    output var logic wrStrobe,
    output var logic [15:0] wrData
);
    initial begin
        {regAddr, rdStrobe, wrStrobe, wrData} = '0;
    end
    // Idle address shows the inverse of the last one
    task automatic rd(input logic [15:0] a, output logic [15:0] d, output bit ok);
        @(posedge sys_clk);
        {regAddr, rdStrobe} <= {a, 1'b1};
        @(posedge sys_clk);
        {regAddr, rdStrobe} <= {~a, 1'b0};
        #1;
        ok = rdValid === 1'b1;
        d = rdData;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        {regAddr, wrData, wrStrobe} <= {a, v, 1'b1};
        @(posedge sys_clk);
        {regAddr, wrData, wrStrobe} <= {~a, ~v, 1'b0};
    endtask
endmodule // poll_master
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic statusEvent, configChange, voltageFault, sensorNight, timingPulse, antennaFault;
    logic overrideActive, inspectionActive, flashDriveInserted, failsafeRunning, isFollower;
    logic leaderSync, leaderModeNight, currentNight, rdStrobe, wrStrobe, rdValid, ok;
    logic [3:0] flashRateSelect, markerBad, markerGood;
    logic [1:0] beaconMissed, beaconFlashed;
    logic [15:0] regAddr, wrData, rdData, base, snap;
    logic [15:0] unused [8] = '{16'h004A, 16'h004B, 16'h004C, 16'h004D, 16'h0050, 16'h0051,
        16'h0054, 16'h0055};
    int errors = 0;
    int check_count = 0;
    always #12.5 sys_clk = ~sys_clk;
    poll_master m (.sys_clk, .rdData, .rdValid, .regAddr, .rdStrobe, .wrStrobe, .wrData);
    tower_alarm_status_regs #(.TICK_CYCLES(4), .SENSOR_WINDOW(50), .SYNC_WINDOW(30),
        .LEADER_WINDOW(20)) uut (.sys_clk, .rst, .regAddr, .rdStrobe, .wrStrobe, .wrData,
        .rdData, .rdValid, .statusEvent, .configChange, .voltageFault, .sensorNight,
        .timingPulse, .antennaFault, .flashRateSelect, .overrideActive, .inspectionActive,
        .flashDriveInserted, .failsafeRunning, .isFollower, .leaderSync, .leaderModeNight,
        .currentNight, .beaconMissed, .beaconFlashed, .markerBad, .markerGood);
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk(input logic [15:0] a, input logic [15:0] e);
        logic [15:0] d;
        bit v;
        m.rd(a, d, v);
        check_count++;
        if (!v || d !== e) begin
            errors++;
            $display("BAD reg %h expected %h seen %h", a, e, d);
        end
    endtask
    task automatic hit(input int k, input bit f);
        @(posedge sys_clk);
        if (k != 0) {markerGood[0], markerBad[0]} <= {f, !f};
        else {beaconFlashed[0], beaconMissed[0]} <= {f, !f};
        @(posedge sys_clk);
        {markerGood, markerBad, beaconFlashed, beaconMissed} <= '0;
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge sys_clk);
        errors++;
        test_done;
    end
    initial begin
        {statusEvent, configChange, voltageFault, sensorNight, timingPulse, antennaFault} = '0;
        {overrideActive, inspectionActive, flashDriveInserted, failsafeRunning} = '0;
        {isFollower, leaderSync, leaderModeNight, currentNight, flashRateSelect} = '0;
        {markerBad, markerGood, beaconMissed, beaconFlashed} = '0;
        cyc(16);
        rst <= 1'b0;
        chk(16'h0048, 16'h0001);
        chk(16'h0048, 16'h0000);
        chk(16'h0049, 16'h0001);
        chk(16'h0049, 16'h0000);
        chk(16'h0046, 16'h0001);
        statusEvent <= 1'b1;
        cyc(3);
        statusEvent <= 1'b0;
        configChange <= 1'b1;
        cyc(2);
        configChange <= 1'b0;
        chk(16'h0046, 16'h0004);
        chk(16'h0047, 16'h0002);
        m.wr(16'h0046, 16'h1234);
        m.wr(16'h0056, 16'h0003);
        chk(16'h0046, 16'h0004);
        chk(16'h0056, 16'h0001);
        foreach (unused[i]) chk(unused[i], 16'hFFFF);
        @(posedge sys_clk);
        {voltageFault, antennaFault, overrideActive, inspectionActive} <= '1;
        {flashDriveInserted, failsafeRunning, sensorNight, currentNight} <= '1;
        {isFollower, leaderModeNight, leaderSync, timingPulse, flashRateSelect} <= 8'hF3;
        @(posedge sys_clk);
        {leaderSync, timingPulse} <= 2'b00;
        chk(16'h0048, 16'h0FC8);
        chk(16'h0049, 16'h0FC8);
        chk(16'h0056, 16'h0003);
        chk(16'h0057, 16'h0003);
        chk(16'h0058, 16'h0003);
        chk(16'h0047, 16'h0003);
        {voltageFault, antennaFault, overrideActive, inspectionActive} <= '0;
        {flashDriveInserted, failsafeRunning, leaderSync, timingPulse} <= 4'h3;
        flashRateSelect <= 4'h1;
        @(posedge sys_clk);
        {leaderSync, timingPulse} <= 2'b00;
        chk(16'h0048, 16'h0000);
        cyc(130);
        chk(16'h0048, 16'h1040);
        cyc(70);
        chk(16'h0048, 16'h1050);
        for (int k = 0; k < 2; k++) begin
            base = k != 0 ? 16'h0052 : 16'h004E;
            repeat (3) hit(k, 1'b0);
            chk(base, 16'h0000);
            hit(k, 1'b0);
            chk(base, 16'h0001);
            chk(base + 16'h0001, 16'h0001);
            chk(base + 16'h0001, 16'h0000);
            hit(k, 1'b1);
            chk(base, 16'h0000);
            chk(base + 16'h0001, 16'h0001);
        end
        m.rd(16'h0046, snap, ok);
        @(posedge sys_clk);
        statusEvent <= 1'b1;
        cyc(65536);
        statusEvent <= 1'b0;
        chk(16'h0046, snap);
        test_done;
    end
endmodule // tb
`default_nettype wire
